// File: include/uga_pkg.sv
// constants and carrier types of the unsolicited grant scheduler
// assumes a single 250 MHz clock and a modem that reports over the link structs below
package uga_pkg;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned TICK_NS       = 1000;
    localparam logic [7:0]  TICK_CYC      = 8'(TICK_NS / CLK_PERIOD_NS);

    // ==========================================================
    // register byte offsets
    localparam logic [5:0] REG_CTRL       = 6'h00;
    localparam logic [5:0] REG_INTERVAL   = 6'h04;
    localparam logic [5:0] REG_POLL       = 6'h08;
    localparam logic [5:0] REG_GRANT_SIZE = 6'h0c;
    localparam logic [5:0] REG_MAX_GPI    = 6'h10;
    localparam logic [5:0] REG_BURST      = 6'h14;
    localparam logic [5:0] REG_DS_RATE    = 6'h18;
    localparam logic [5:0] REG_STATUS     = 6'h1c;
    localparam logic [5:0] REG_EXTRAS     = 6'h20;

    // ==========================================================
    // field positions and reset values
    localparam int unsigned CTRL_EN_BIT    = 0;
    localparam int unsigned CTRL_AD_BIT    = 1;
    localparam int unsigned STAT_GRANT_BIT = 0;
    localparam int unsigned STAT_BKLG_BIT  = 1;
    localparam int unsigned STAT_GPI_LSB   = 4;
    localparam logic [15:0] GRANT_SIZE_RST = 16'h00c8;
    localparam logic [3:0]  MAX_GPI_RST    = 4'h1;
    localparam logic [3:0]  BURST_RST      = 4'h2;
    localparam logic [7:0]  DS_RATE_RST    = 8'h01;
    localparam logic [6:0]  EXTRA_PERIOD   = 7'h64;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic        en;
        logic        ad_mode;
        logic [15:0] interval_us;
        logic [15:0] poll_us;
        logic [15:0] grant_size;
        logic [3:0]  max_gpi;
        logic [3:0]  burst;
        logic [7:0]  ds_rate;
    } uga_cfg_s;

    typedef struct packed {
        logic        granting;
        logic        backlog;
        logic [3:0]  gpi;
        logic [15:0] extras;
    } uga_stat_s;

    typedef struct packed {
        logic       valid;
        logic       is_request;
        logic       queue_ind;
        logic [3:0] active;
    } uga_rx_s;

    typedef struct packed {
        logic        grant;
        logic        poll;
        logic        extra;
        logic [15:0] size;
    } uga_tx_s;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_POLL,
        ST_GRANT
    } uga_mode_e;

    typedef struct packed {
        logic       tick;
        logic [7:0] cnt;
    } uga_tick_s;

    typedef struct packed {
        logic        wait_q;
        logic [31:0] rdata;
        uga_cfg_s    cfg;
    } uga_regs_s;

    typedef struct packed {
        uga_mode_e   mode;
        logic [3:0]  gpi;
        logic [15:0] us_cnt;
        logic [15:0] poll_cnt;
        logic [3:0]  pend;
        logic [3:0]  extra_pend;
        logic        backlog;
        logic [6:0]  since_extra;
        logic [15:0] extras;
        logic [8:0]  ds_cnt;
        uga_tx_s     tx;
        logic        ds_pass;
        logic        ds_drop;
    } uga_sched_s;

endpackage

// File: rtl/uga_tick.sv
// microsecond enable divider for the scheduler
// assumes i_clk at the package clock period
`timescale 1ns/1ps
module uga_tick
    import uga_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    output logic      o_tick
);
    uga_tick_s q;
    uga_tick_s d;

    // ==========================================================
    // divider
    always_comb begin
        d      = q;
        d.tick = 1'h0;
        if (q.cnt == TICK_CYC - 8'h01) begin
            d.cnt  = 8'h00;
            d.tick = 1'h1;
        end else begin
            d.cnt = q.cnt + 8'h01;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_tick = q.tick;
endmodule

// File: rtl/uga_regs.sv
// avalon-mm slave holding scheduler configuration and showing its status
// assumes a master that holds its request until waitrequest is seen low
`timescale 1ns/1ps
module uga_regs
    import uga_pkg::*;
#(
    parameter logic [15:0] P_INTERVAL_US = 16'h2710,
    parameter logic [15:0] P_POLL_US     = 16'h1388
)(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire uga_stat_s   i_stat,
    output uga_cfg_s         o_cfg
);
    uga_regs_s q;
    uga_regs_s d;

    // ==========================================================
    // read mux, unmapped reads give zero
    function automatic logic [31:0] rd(input logic [5:0] a, input uga_cfg_s c, input uga_stat_s s);
        logic [31:0] r;
        r = '0;
        case (a)
            REG_CTRL: begin
                r[CTRL_EN_BIT] = c.en;
                r[CTRL_AD_BIT] = c.ad_mode;
            end
            REG_INTERVAL:   r[15:0] = c.interval_us;
            REG_POLL:       r[15:0] = c.poll_us;
            REG_GRANT_SIZE: r[15:0] = c.grant_size;
            REG_MAX_GPI:    r[3:0]  = c.max_gpi;
            REG_BURST:      r[3:0]  = c.burst;
            REG_DS_RATE:    r[7:0]  = c.ds_rate;
            REG_STATUS: begin
                r[STAT_GRANT_BIT]               = s.granting;
                r[STAT_BKLG_BIT]                = s.backlog;
                r[STAT_GPI_LSB +: 4]            = s.gpi;
            end
            REG_EXTRAS:     r[15:0] = s.extras;
            default:        r = '0;
        endcase
        return r;
    endfunction

    // ==========================================================
    // one wait state, write lands on the edge that sees waitrequest low
    always_comb begin
        d        = q;
        d.wait_q = 1'h1;
        if ((i_avs_read || i_avs_write) && q.wait_q) begin
            d.wait_q = 1'h0;
            d.rdata  = rd(i_avs_address, q.cfg, i_stat);
        end
        if (i_avs_write && !q.wait_q) begin
            case (i_avs_address)
                REG_CTRL: begin
                    d.cfg.en      = i_avs_writedata[CTRL_EN_BIT];
                    d.cfg.ad_mode = i_avs_writedata[CTRL_AD_BIT];
                end
                REG_INTERVAL:   d.cfg.interval_us = i_avs_writedata[15:0];
                REG_POLL:       d.cfg.poll_us     = i_avs_writedata[15:0];
                REG_GRANT_SIZE: d.cfg.grant_size  = i_avs_writedata[15:0];
                REG_MAX_GPI:    d.cfg.max_gpi     = i_avs_writedata[3:0];
                REG_BURST:      d.cfg.burst       = i_avs_writedata[3:0];
                REG_DS_RATE:    d.cfg.ds_rate     = i_avs_writedata[7:0];
                default:        d.cfg = q.cfg;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q                 <= '0;
            q.wait_q          <= 1'h1;
            q.cfg.interval_us <= P_INTERVAL_US;
            q.cfg.poll_us     <= P_POLL_US;
            q.cfg.grant_size  <= GRANT_SIZE_RST;
            q.cfg.max_gpi     <= MAX_GPI_RST;
            q.cfg.burst       <= BURST_RST;
            q.cfg.ds_rate     <= DS_RATE_RST;
        end else begin
            q <= d;
        end
    end

    assign o_avs_readdata    = q.rdata;
    assign o_avs_waitrequest = q.wait_q;
    assign o_cfg             = q.cfg;
endmodule

// File: rtl/uga_sched.sv
// head-end upstream scheduler for one constant-rate flow with optional activity detection
// assumes modem reports arrive as one-cycle uga_rx_s pulses on i_clk, one per packet
// How it works
// RULE1: grant spacing equals the packet period, programmed in microseconds, default 10 ms
// RULE2: several subflows share a pool of grants per interval, no subflow mapping
// RULE3: modem sends one whole packet per grant, no concatenation or fragments
// RULE4: single grant lands between nominal time and nominal plus jitter
// RULE5: last grant of a group lands within jitter after nominal time
// RULE6: modem raises backlog bit while its queue builds and drops it after
// RULE7: backlog adds at most one extra grant per hundred, stops when cleared
// RULE8: downstream policed slightly above provisioned rate per interval
// RULE9: activity mode polls while inactive and grants while active
// RULE10: modem reports needed grants per interval, never above the maximum
// RULE11: modem may time subflow activity per classifier, count equals active subflows
// RULE12: modem requests one grant when polled, reports full count from first packet
// RULE13: raised grant count brings a close burst of extra grants
// RULE14: modem sends one zero-count packet when idle, then goes quiet
// RULE15: zero-count packet stops grants and switches to polling
// RULE16: request in a poll resumes grants of configured size, request size ignored
// RULE17: modem restarts through polls or grants, scheduler may miss the zero packet
// RULE18: modem resets to no backlog, all subflows inactive, zero grants
`timescale 1ns/1ps
module uga_sched
    import uga_pkg::*;
#(
    parameter logic [15:0] P_INTERVAL_US = 16'h2710,
    parameter logic [15:0] P_POLL_US     = 16'h1388
)(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire uga_rx_s     i_rx,
    output uga_tx_s          o_tx,
    input  wire logic        i_ds_valid,
    output logic             o_ds_pass,
    output logic             o_ds_drop
);
    uga_sched_s q;
    uga_sched_s d;
    uga_cfg_s   cfg;
    uga_stat_s  stat;
    logic       tick;
    logic       nominal;
    logic       poll_due;

    // ==========================================================
    // downstream budget per interval, a sixteenth above the rate plus one
    function automatic logic [8:0] ds_budget(input logic [7:0] rate);
        return {1'h0, rate} + {5'h00, rate[7:4]} + 9'h001;
    endfunction

    // ==========================================================
    // helpers
    uga_tick u_tick (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .o_tick (tick)
    );

    uga_regs #(
        .P_INTERVAL_US (P_INTERVAL_US),
        .P_POLL_US     (P_POLL_US)
    ) u_regs (
        .i_clk             (i_clk),
        .i_rst             (i_rst),
        .i_avs_address     (i_avs_address),
        .i_avs_read        (i_avs_read),
        .i_avs_write       (i_avs_write),
        .i_avs_writedata   (i_avs_writedata),
        .o_avs_readdata    (o_avs_readdata),
        .o_avs_waitrequest (o_avs_waitrequest),
        .i_stat            (stat),
        .o_cfg             (cfg)
    );

    assign stat.granting = (q.mode == ST_GRANT);
    assign stat.backlog  = q.backlog;
    assign stat.gpi      = q.gpi;
    assign stat.extras   = q.extras;

    // RULE1: nominal grant time
    assign nominal  = tick && ({1'h0, q.us_cnt} + 17'h00001 >= {1'h0, cfg.interval_us});
    // RULE9: poll opportunity time
    assign poll_due = tick && ({1'h0, q.poll_cnt} + 17'h00001 >= {1'h0, cfg.poll_us});

    // ==========================================================
    // scheduler
    always_comb begin
        d         = q;
        d.tx      = '0;
        d.ds_pass = 1'h0;
        d.ds_drop = 1'h0;

        if (tick) begin
            d.us_cnt   = nominal ? 16'h0000 : q.us_cnt + 16'h0001;
            d.poll_cnt = poll_due ? 16'h0000 : q.poll_cnt + 16'h0001;
        end

        // emission: group first, then talk spurt burst, then backlog extra
        // RULE4: group starts the cycle after nominal, one grant a cycle
        if (q.pend != 4'h0) begin
            d.tx.grant = 1'h1;
            d.tx.size  = cfg.grant_size;
            d.pend     = q.pend - 4'h1;
            if (q.since_extra != EXTRA_PERIOD - 7'h01) begin
                d.since_extra = q.since_extra + 7'h01;
            end
        // RULE13: burst extras close together
        end else if (q.extra_pend != 4'h0 && q.mode == ST_GRANT) begin
            d.tx.grant     = 1'h1;
            d.tx.extra     = 1'h1;
            d.tx.size      = cfg.grant_size;
            d.extra_pend   = q.extra_pend - 4'h1;
        // RULE7: at most one backlog extra per hundred grants
        end else if (q.backlog && q.mode == ST_GRANT && q.since_extra == EXTRA_PERIOD - 7'h01) begin
            d.tx.grant     = 1'h1;
            d.tx.extra     = 1'h1;
            d.tx.size      = cfg.grant_size;
            d.since_extra  = 7'h00;
            d.extras       = q.extras + 16'h0001;
        end

        // RULE9: polls only while inactive
        if (q.mode == ST_POLL && poll_due) begin
            d.tx.poll = 1'h1;
        end

        case (q.mode)
            ST_OFF: begin
                if (cfg.en) begin
                    d.mode = cfg.ad_mode ? ST_POLL : ST_GRANT;
                    d.gpi  = cfg.ad_mode ? 4'h0 : cfg.max_gpi;
                end
            end
            ST_POLL: begin
                // RULE16: any request resumes grants, its size is ignored
                if (i_rx.valid && i_rx.is_request) begin
                    d.mode       = ST_GRANT;
                    d.gpi        = 4'h1;
                    d.extra_pend = cfg.burst;
                // RULE17: a data packet means the modem restarted in a grant we never stopped
                end else if (i_rx.valid && i_rx.active != 4'h0) begin
                    d.mode       = ST_GRANT;
                    d.gpi        = (i_rx.active > cfg.max_gpi) ? cfg.max_gpi : i_rx.active;
                    d.extra_pend = cfg.burst;
                end
            end
            ST_GRANT: begin
                if (!cfg.ad_mode) begin
                    d.gpi = cfg.max_gpi;
                end else if (i_rx.valid && !i_rx.is_request) begin
                    // RULE15: zero count ends grants, back to polling
                    if (i_rx.active == 4'h0) begin
                        d.mode       = ST_POLL;
                        d.gpi        = 4'h0;
                        d.pend       = 4'h0;
                        d.extra_pend = 4'h0;
                        d.tx.grant   = 1'h0;
                        d.tx.extra   = 1'h0;
                        d.tx.size    = 16'h0000;
                    end else begin
                        // RULE2: pool size follows the reported count, capped
                        d.gpi = (i_rx.active > cfg.max_gpi) ? cfg.max_gpi : i_rx.active;
                        // RULE13: more subflows, drain the build up
                        if (d.gpi > q.gpi) begin
                            d.extra_pend = cfg.burst;
                        end
                    end
                end
            end
            default: begin
                d.mode = ST_OFF;
            end
        endcase

        // RULE6: backlog follows the queue bit of each data packet, forced low outside ST_GRANT
        if (i_rx.valid && !i_rx.is_request) begin
            d.backlog = i_rx.queue_ind;
        end
        if (d.mode != ST_GRANT) begin
            d.backlog = 1'h0;
        end

        // RULE1: one group per nominal interval
        if (nominal && d.mode == ST_GRANT) begin
            d.pend = d.gpi;
        end

        // RULE8: per interval downstream count
        if (nominal) begin
            d.ds_cnt = 9'h000;
        end
        if (i_ds_valid) begin
            if (d.ds_cnt < ds_budget(cfg.ds_rate)) begin
                d.ds_pass = 1'h1;
                d.ds_cnt  = d.ds_cnt + 9'h001;
            end else begin
                d.ds_drop = 1'h1;
            end
        end

        // disable wins over all grant and poll state, downstream policing keeps running
        if (!cfg.en) begin
            d.mode       = ST_OFF;
            d.gpi        = 4'h0;
            d.pend       = 4'h0;
            d.extra_pend = 4'h0;
            d.backlog    = 1'h0;
            d.tx         = '0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q      <= '0;
            q.mode <= ST_OFF;
        end else begin
            q <= d;
        end
    end

    assign o_tx      = q.tx;
    assign o_ds_pass = q.ds_pass;
    assign o_ds_drop = q.ds_drop;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_group_start;
        nominal && d.mode == ST_GRANT && cfg.en && d.gpi != 4'h0;
    endsequence

    sequence s_resume;
        cfg.en && q.mode == ST_POLL && i_rx.valid && i_rx.is_request;
    endsequence

    chk_nominal_group: assert property ( // RULE1
        s_group_start |=> q.pend == $past(d.gpi)
    ) else $error("group size not loaded at nominal time");

    chk_group_last: assert property ( // RULE4 RULE5
        s_group_start |-> ##[1:17] (q.pend == 4'h0)
    ) else $error("grant group not finished within window");

    chk_pool_size: assert property ( // RULE2
        (cfg.en && cfg.ad_mode && q.mode == ST_GRANT && i_rx.valid && !i_rx.is_request
         && i_rx.active != 4'h0 && i_rx.active <= cfg.max_gpi) |=> q.gpi == $past(i_rx.active)
    ) else $error("pool size does not follow reported count");

    chk_backlog_spacing: assert property ( // RULE7
        (q.since_extra == 7'h00 && $past(q.since_extra) == EXTRA_PERIOD - 7'h01)
        |-> q.tx.grant && q.tx.extra && $past(q.backlog)
    ) else $error("backlog extra grant spacing wrong");

    chk_backlog_stop: assert property ( // RULE7
        (q.tx.grant && q.tx.extra && $past(q.extra_pend) == 4'h0) |-> $past(q.backlog)
    ) else $error("extra grant without backlog");

    chk_ds_police: assert property ( // RULE8
        q.ds_drop |-> q.ds_cnt == ds_budget($past(cfg.ds_rate))
    ) else $error("downstream dropped below budget");

    chk_poll_only: assert property ( // RULE9
        q.tx.poll |-> $past(q.mode) == ST_POLL && !q.tx.grant
    ) else $error("poll sent outside polling mode");

    chk_zero_stop: assert property ( // RULE15
        (cfg.en && cfg.ad_mode && q.mode == ST_GRANT && i_rx.valid && !i_rx.is_request
         && i_rx.active == 4'h0) |=> q.mode == ST_POLL && q.pend == 4'h0 && !q.tx.grant
    ) else $error("grants not stopped on zero count");

    chk_request_resume: assert property ( // RULE16 RULE13
        s_resume |=> q.mode == ST_GRANT && q.gpi == 4'h1 && q.extra_pend == $past(cfg.burst)
    ) else $error("request in poll did not resume grants");

    chk_grant_size: assert property ( // RULE16
        q.tx.grant |-> q.tx.size == $past(cfg.grant_size)
    ) else $error("grant size differs from configured size");
endmodule

// File: sim/uga_modem.sv
// behavioural modem answering grants and polls of the scheduler
// assumes one-cycle grant and poll pulses; bench sets active subflows and backlog
`timescale 1ns/1ps
module uga_modem
    import uga_pkg::*;
#(
    parameter logic [3:0] P_MAX = 4'h4
)(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire uga_tx_s    i_tx,
    input  wire logic [3:0] i_act,
    input  wire logic       i_bklg,
    output uga_rx_s         o_rx
);
    // ==========================================================
    // packet and request generation
    logic quiet_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx    <= '0;
            quiet_q <= 1'b1;
        end else begin
            o_rx <= '0;
            if (i_tx.grant && !(quiet_q && i_act == 4'h0)) begin
                o_rx.valid <= 1'b1;
                o_rx.queue_ind <= i_bklg;
                o_rx.active <= (i_act > P_MAX) ? P_MAX : i_act;
                quiet_q     <= (i_act == 4'h0);
            end else if (i_tx.poll && quiet_q && i_act != 4'h0) begin
                o_rx.valid      <= 1'b1;
                o_rx.is_request <= 1'b1;
                quiet_q         <= 1'b0;
            end
        end
    end
endmodule

// File: sim/uga_sched_test.sv
// self-checking bench for the grant scheduler
// assumes uga_modem as far side and the package register map
`timescale 1ns/1ps
module uga_sched_test
    import uga_pkg::*;
;
    logic        i_clk, i_rst, av_rd, av_wr, wreq, ds, ps, dp, bklg;
    logic [5:0]  adr;
    logic [31:0] wd, rdat, q;
    logic [3:0]  act;
    uga_rx_s     rx;
    uga_tx_s     tx;
    int          num_errors, num_checks, b, g, e, gp;
    int          ng = 0, ne = 0, np = 0, npass = 0, ndrop = 0, cyc = 0, gs0 = 0, gs1 = 0;
    logic [15:0] sz;

    uga_sched #(.P_INTERVAL_US(16'h0004), .P_POLL_US(16'h0002)) uga_sched_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(av_rd), .i_avs_write(av_wr),
        .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_rx(rx), .o_tx(tx),
        .i_ds_valid(ds), .o_ds_pass(ps), .o_ds_drop(dp));
    uga_modem uga_modem_inst (.i_clk(i_clk), .i_rst(i_rst), .i_tx(tx), .i_act(act), .i_bklg(bklg), .o_rx(rx));

    // ==========================================================
    // monitor; group start is a plain grant after an idle cycle
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        gp  <= (tx.grant === 1'b1);
        if (tx.grant === 1'b1) begin
            ng <= ng + 1;
            sz <= tx.size;
            if (tx.extra === 1'b1) ne <= ne + 1;
            if (tx.extra === 1'b0 && gp == 0) begin
                gs0 <= gs1;
                gs1 <= cyc;
            end
        end
        if (tx.poll === 1'b1) np <= np + 1;
        if (ps === 1'b1) npass <= npass + 1;
        if (dp === 1'b1) ndrop <= ndrop + 1;
    end

    // ==========================================================
    // shared tasks
    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        num_checks++;
        if (s !== x) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
        end
    endtask
    // request held until the rising edge that samples waitrequest low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a; av_wr <= w; av_rd <= ~w; wd <= d;
        do begin
            @(posedge i_clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdat;
        av_rd <= 1'b0; av_wr <= 1'b0;
        // one idle edge so the next call never re-raises in this step
        @(posedge i_clk);
        if (n >= 20) begin num_errors++; results; end
    endtask
    task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask
    // lands 100 cycles after the next grant it sees on a falling edge
    task automatic sync;
        int n;
        n = 0;
        @(negedge i_clk);
        while (tx.grant !== 1'b1 && n < 3000) begin @(negedge i_clk); n++; end
        repeat (100) @(posedge i_clk);
        if (n >= 3000) begin num_errors++; results; end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        rchk("ctrl", REG_CTRL, 32'h0);
        rchk("gsize", REG_GRANT_SIZE, {16'h0, GRANT_SIZE_RST});
        rchk("status", REG_STATUS, 32'h0);
        rchk("unmapped", 6'h3c, 32'h0);
    endtask
    task automatic t_plain;
        bus(1'b1, REG_MAX_GPI, 32'h3);
        bus(1'b1, REG_CTRL, 32'h1);
        sync;
        b = npass; e = ndrop;
        ds <= 1'b1;
        repeat (3) @(posedge i_clk);
        ds <= 1'b0;
        g = ng;
        repeat (3000) @(posedge i_clk);
        chk("pass", 32'h2, 32'(npass - b));
        chk("drop", 32'h1, 32'(ndrop - e));
        chk("grants", 32'h9, 32'(ng - g));
        chk("spacing", 32'd1000, 32'(gs1 - gs0));
        chk("size", {16'h0, GRANT_SIZE_RST}, {16'h0, sz});
        rchk("status", REG_STATUS, 32'h31);
    endtask
    task automatic t_backlog;
        bus(1'b1, REG_INTERVAL, 32'h2);
        bus(1'b1, REG_MAX_GPI, 32'h4);
        // modem must talk for its queue bit to reach the scheduler
        act  <= 4'h1;
        bklg <= 1'b1;
        sync;
        g = ng; e = ne;
        repeat (13000) @(posedge i_clk);
        chk("bklg_extras", 32'h1, 32'((ne - e) >= 1 && (ne - e) <= (ng - g) / 100 + 1));
        rchk("status", REG_STATUS, 32'h43);
        bklg <= 1'b0;
        act  <= 4'h0;
        repeat (1200) @(posedge i_clk);
        e = ne;
        repeat (2000) @(posedge i_clk);
        chk("no_extras", 32'h0, 32'(ne - e));
        rchk("status", REG_STATUS, 32'h41);
    endtask
    task automatic t_ad;
        bus(1'b1, REG_CTRL, 32'h0);
        bus(1'b1, REG_CTRL, 32'h3);
        b = np; g = ng;
        repeat (2000) @(posedge i_clk);
        chk("polls", 32'h1, 32'((np - b) >= 3));
        chk("idle_grants", 32'h0, 32'(ng - g));
        act <= 4'h2;
        e = ne;
        repeat (1200) @(posedge i_clk);
        // burst on restart and again on the raise to two
        chk("burst", 32'h4, 32'(ne - e));
        rchk("status", REG_STATUS, 32'h21);
        act <= 4'h0;
        repeat (600) @(posedge i_clk);
        b = np; g = ng;
        repeat (1500) @(posedge i_clk);
        chk("stop_grants", 32'h0, 32'(ng - g));
        chk("repoll", 32'h1, 32'((np - b) >= 2));
        rchk("status", REG_STATUS, 32'h0);
    endtask

    // ==========================================================
    // clock, sequence, watchdog
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        i_rst = 1'b1; av_rd = 1'b0; av_wr = 1'b0; adr = 6'h0; wd = 32'h0;
        ds = 1'b0; act = 4'h0; bklg = 1'b0; num_errors = 0; num_checks = 0;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_reset;
        t_plain;
        t_backlog;
        t_ad;
        results;
    end
    initial begin
        repeat (100000) @(posedge i_clk);
        num_errors++;
        results;
    end
endmodule
